// ===== core/pin_pulse_timing_pkg.sv
package pin_pulse_timing_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] DATA_PIN_DIRECTION_OFS = 12'h000;
	localparam logic [11:0] CMD_OFS = 12'h004;
	localparam logic [11:0] DURATION_OFS = 12'h008;
	localparam logic [11:0] HIGH_TIME_OFS = 12'h00C;
	localparam logic [11:0] CYCLE_TIME_OFS = 12'h010;
	localparam logic [11:0] CYCLE_COUNT_OFS = 12'h014;
	localparam logic [11:0] STATUS_OFS = 12'h018;
	localparam logic [11:0] RESULT_OFS = 12'h01C;
	localparam logic [7:0] DATA_PIN_DIRECTION_RST = 8'hFF;
	// ----------------------------------------
	// Command and status register fields, pin count
	// ----------------------------------------
	localparam int CMD_PIN_LSB = 0;
	localparam int CMD_OP_LSB = 8;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	localparam int NUM_PINS = 16;
	// ----------------------------------------
	// Operations
	// ----------------------------------------
	localparam logic [2:0] OP_PULSE_IN_LOW = 3'h1;
	localparam logic [2:0] OP_PULSE_IN_HIGH = 3'h2;
	localparam logic [2:0] OP_PULSE_OUT_LOW = 3'h3;
	localparam logic [2:0] OP_PULSE_OUT_HIGH = 3'h4;
	localparam logic [2:0] OP_CYCLES = 3'h5;
	localparam logic [2:0] OP_RC_DISCHARGE = 3'h6;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int PULSE_TICK_US = 10;
	localparam int PULSE_TICK_CYCLES = PULSE_TICK_US * CLK_MHZ;
	localparam int CYCLE_TICK_US = 3;
	localparam int CYCLE_TICK_CYCLES = CYCLE_TICK_US * CLK_MHZ;
	localparam int RC_CHARGE_TICKS = 10;
	localparam int RC_MIN_COUNT = 2;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage : pin_pulse_timing_pkg

// ===== core/pin_pulse_timing_unit.sv
// Overview of operation
// - An 8-bit data pin direction register is written whole; 0 makes a pin output, 1 input.
// - A low-pulse measurement times the low level on a pin in 10 us counts, 16 bits wide.
// - A high-pulse measurement times the high level on a pin in 10 us counts, 16 bits wide.
// - A pulse measurement returns zero if no pulse is seen or it exceeds the 16-bit range.
// - A low-pulse output drives the pin low for the given 10 us counts, then high.
// - A high-pulse output drives the pin high for the given 10 us counts, then low.
// - A cycle burst emits exactly the requested periods of high time then low up to cycle time.
// - Burst high and cycle times count in units of about 3 us.
// - The burst duty ratio is resolved with up to 16-bit precision.
// - Burst output frequency spans roughly 5 to 166K cycles per second.
// - An RC measurement times the discharge of a parallel RC on a pin as a 16-bit count.
// - An RC measurement returns zero if discharge is too short or times run out of range.
// - Pins are selected by an 8-bit number 0 to 15 over data and address port pins.
`timescale 1ns/1ns
module pin_pulse_timing_unit (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] pinIn,
	output logic [15:0] pinOut,
	output logic [15:0] pinOe_n,
	output logic [7:0] addrPinDirection,
	output logic done
);
	typedef enum {
		ST_IDLE, ST_WAIT_LEAD, ST_MEASURE, ST_PULSE_OUT, ST_CYC_HIGH, ST_CYC_LOW,
		ST_RC_CHARGE, ST_RC_DISCHARGE
	} state_t;

	// ----------------------------------------
	// Input synchronisers and timebases
	// ----------------------------------------
	logic [15:0] pinSync;
	logic tick10, tick3, tickRestart;
	pin_sync #(.WIDTH(pin_pulse_timing_pkg::NUM_PINS)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pinIn(pinIn),
		.pinSync(pinSync)
	);
	tick_divider #(.DIVIDE(pin_pulse_timing_pkg::PULSE_TICK_CYCLES)) u_tick10 (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.restart(tickRestart),
		.tick(tick10)
	);
	tick_divider #(.DIVIDE(pin_pulse_timing_pkg::CYCLE_TICK_CYCLES)) u_tick3 (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.restart(tickRestart),
		.tick(tick3)
	);
	// ----------------------------------------
	// State
	// ----------------------------------------
	state_t state_q, state_d;
	logic [7:0] dirData_q, dirData_d;
	logic [15:0] outLevel_q, outLevel_d;
	logic [15:0] duration_q, duration_d;
	logic [15:0] highTime_q, highTime_d;
	logic [15:0] cycleTime_q, cycleTime_d;
	logic [15:0] cycleCount_q, cycleCount_d;
	logic [15:0] result_q, result_d;
	logic [15:0] count_q, count_d;
	logic [15:0] periods_q, periods_d;
	logic [3:0] pin_q, pin_d;
	logic [2:0] op_q, op_d;
	logic level_q, level_d;
	logic done_q, done_d;
	logic forceOut_q, forceOut_d;
	logic [31:0] prdata_q, prdata_d;
	logic wrAccess, rdAccess, mapped, pinLevel, busy;
	logic [7:0] cmdPin;
	logic [2:0] cmdOp;
	always_comb begin
		wrAccess = psel && penable && pwrite;
		rdAccess = psel && !penable && !pwrite; // Loaded in setup, stands through access
		pinLevel = pinSync[pin_q];
		busy = (state_q != ST_IDLE);
		cmdPin = pwdata[pin_pulse_timing_pkg::CMD_PIN_LSB +: 8];
		cmdOp = pwdata[pin_pulse_timing_pkg::CMD_OP_LSB +: 3];
		case (paddr)
			pin_pulse_timing_pkg::DATA_PIN_DIRECTION_OFS,
			pin_pulse_timing_pkg::CMD_OFS,
			pin_pulse_timing_pkg::DURATION_OFS,
			pin_pulse_timing_pkg::HIGH_TIME_OFS,
			pin_pulse_timing_pkg::CYCLE_TIME_OFS,
			pin_pulse_timing_pkg::CYCLE_COUNT_OFS,
			pin_pulse_timing_pkg::STATUS_OFS,
			pin_pulse_timing_pkg::RESULT_OFS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Register file and sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		dirData_d = dirData_q;
		outLevel_d = outLevel_q;
		duration_d = duration_q;
		highTime_d = highTime_q;
		cycleTime_d = cycleTime_q;
		cycleCount_d = cycleCount_q;
		result_d = result_q;
		count_d = count_q;
		periods_d = periods_q;
		pin_d = pin_q;
		op_d = op_q;
		level_d = level_q;
		done_d = done_q;
		forceOut_d = forceOut_q;
		prdata_d = prdata_q;
		tickRestart = 1'b0;
		if (rdAccess) begin
			case (paddr)
				pin_pulse_timing_pkg::DATA_PIN_DIRECTION_OFS: prdata_d = {24'h000000, dirData_q};
				pin_pulse_timing_pkg::DURATION_OFS: prdata_d = {16'h0000, duration_q};
				pin_pulse_timing_pkg::HIGH_TIME_OFS: prdata_d = {16'h0000, highTime_q};
				pin_pulse_timing_pkg::CYCLE_TIME_OFS: prdata_d = {16'h0000, cycleTime_q};
				pin_pulse_timing_pkg::CYCLE_COUNT_OFS: prdata_d = {16'h0000, cycleCount_q};
				pin_pulse_timing_pkg::STATUS_OFS: prdata_d = {30'h0, done_q, busy};
				pin_pulse_timing_pkg::RESULT_OFS: prdata_d = {16'h0000, result_q};
				default: prdata_d = 32'h00000000;
			endcase
		end
		if (wrAccess) begin
			case (paddr)
				pin_pulse_timing_pkg::DATA_PIN_DIRECTION_OFS: dirData_d = pwdata[7:0];
				pin_pulse_timing_pkg::DURATION_OFS: duration_d = pwdata[15:0];
				pin_pulse_timing_pkg::HIGH_TIME_OFS: highTime_d = pwdata[15:0];
				pin_pulse_timing_pkg::CYCLE_TIME_OFS: cycleTime_d = pwdata[15:0];
				pin_pulse_timing_pkg::CYCLE_COUNT_OFS: cycleCount_d = pwdata[15:0];
				default: ;
			endcase
		end
		case (state_q)
			ST_IDLE: begin
				// Commands ignored unless idle and pin in 0..15
				if (wrAccess && paddr == pin_pulse_timing_pkg::CMD_OFS && cmdPin < 8'h10) begin
					pin_d = cmdPin[3:0];
					op_d = cmdOp;
					count_d = 16'h0000;
					periods_d = 16'h0000;
					tickRestart = 1'b1;
					done_d = 1'b0;
					case (cmdOp)
						pin_pulse_timing_pkg::OP_PULSE_IN_LOW,
						pin_pulse_timing_pkg::OP_PULSE_IN_HIGH: begin
							level_d = 1'b0;
							state_d = ST_WAIT_LEAD;
						end
						pin_pulse_timing_pkg::OP_PULSE_OUT_LOW: begin
							outLevel_d[cmdPin[3:0]] = 1'b0;
							state_d = ST_PULSE_OUT;
						end
						pin_pulse_timing_pkg::OP_PULSE_OUT_HIGH: begin
							outLevel_d[cmdPin[3:0]] = 1'b1;
							state_d = ST_PULSE_OUT;
						end
						pin_pulse_timing_pkg::OP_CYCLES: begin
							if (cycleCount_q == 16'h0000) begin
								result_d = 16'h0000;
								done_d = 1'b1;
							end else begin
								outLevel_d[cmdPin[3:0]] = 1'b1;
								state_d = ST_CYC_HIGH;
							end
						end
						pin_pulse_timing_pkg::OP_RC_DISCHARGE: begin
							outLevel_d[cmdPin[3:0]] = 1'b1;
							forceOut_d = 1'b1;
							state_d = ST_RC_CHARGE;
						end
						default: done_d = 1'b1;
					endcase
				end
			end
			ST_WAIT_LEAD: begin
				// level_q tracks that the idle level was seen first
				if (pinLevel == (op_q == pin_pulse_timing_pkg::OP_PULSE_IN_LOW)) begin
					level_d = 1'b1;
				end else if (level_q) begin
					count_d = 16'h0000;
					tickRestart = 1'b1;
					state_d = ST_MEASURE;
				end
				if (tick10 && state_d == ST_WAIT_LEAD) begin
					if (count_q == pin_pulse_timing_pkg::COUNT_MAX) begin
						result_d = 16'h0000;
						done_d = 1'b1;
						state_d = ST_IDLE;
					end else begin
						count_d = count_q + 16'h0001;
					end
				end
			end
			ST_MEASURE: begin
				if (pinLevel == (op_q == pin_pulse_timing_pkg::OP_PULSE_IN_LOW)) begin
					result_d = count_q;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end else if (tick10) begin
					if (count_q == pin_pulse_timing_pkg::COUNT_MAX) begin
						result_d = 16'h0000;
						done_d = 1'b1;
						state_d = ST_IDLE;
					end else begin
						count_d = count_q + 16'h0001;
					end
				end
			end
			ST_PULSE_OUT: begin
				if (count_q == duration_q) begin
					outLevel_d[pin_q] = (op_q == pin_pulse_timing_pkg::OP_PULSE_OUT_LOW);
					done_d = 1'b1;
					state_d = ST_IDLE;
				end else if (tick10) begin
					count_d = count_q + 16'h0001;
				end
			end
			ST_CYC_HIGH: begin
				if (count_q >= highTime_q) begin
					outLevel_d[pin_q] = 1'b0;
					state_d = ST_CYC_LOW;
				end else if (tick3) begin
					count_d = count_q + 16'h0001;
				end
			end
			ST_CYC_LOW: begin
				if (count_q >= cycleTime_q) begin
					count_d = 16'h0000;
					if (periods_q + 16'h0001 == cycleCount_q) begin
						done_d = 1'b1;
						state_d = ST_IDLE;
					end else begin
						periods_d = periods_q + 16'h0001;
						outLevel_d[pin_q] = 1'b1;
						state_d = ST_CYC_HIGH;
					end
				end else if (tick3) begin
					count_d = count_q + 16'h0001;
				end
			end
			ST_RC_CHARGE: begin
				if (tick10) begin
					if (count_q == 16'(pin_pulse_timing_pkg::RC_CHARGE_TICKS - 1)) begin
						forceOut_d = 1'b0;
						count_d = 16'h0000;
						state_d = ST_RC_DISCHARGE;
					end else begin
						count_d = count_q + 16'h0001;
					end
				end
			end
			ST_RC_DISCHARGE: begin
				if (!pinLevel) begin
					result_d = (count_q < 16'(pin_pulse_timing_pkg::RC_MIN_COUNT)) ? 16'h0000 : count_q;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end else if (tick10) begin
					if (count_q == pin_pulse_timing_pkg::COUNT_MAX) begin
						result_d = 16'h0000;
						done_d = 1'b1;
						state_d = ST_IDLE;
					end else begin
						count_d = count_q + 16'h0001;
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			dirData_q <= pin_pulse_timing_pkg::DATA_PIN_DIRECTION_RST;
			outLevel_q <= 16'h0000;
			duration_q <= 16'h0000;
			highTime_q <= 16'h0000;
			cycleTime_q <= 16'h0000;
			cycleCount_q <= 16'h0000;
			result_q <= 16'h0000;
			count_q <= 16'h0000;
			periods_q <= 16'h0000;
			pin_q <= 4'h0;
			op_q <= 3'h0;
			level_q <= 1'b0;
			done_q <= 1'b0;
			forceOut_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			dirData_q <= dirData_d;
			outLevel_q <= outLevel_d;
			duration_q <= duration_d;
			highTime_q <= highTime_d;
			cycleTime_q <= cycleTime_d;
			cycleCount_q <= cycleCount_d;
			result_q <= result_d;
			count_q <= count_d;
			periods_q <= periods_d;
			pin_q <= pin_d;
			op_q <= op_d;
			level_q <= level_d;
			done_q <= done_d;
			forceOut_q <= forceOut_d;
			prdata_q <= prdata_d;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		pinOut = outLevel_q;
		pinOe_n = {pin_pulse_timing_pkg::DATA_PIN_DIRECTION_RST, dirData_q};
		if (forceOut_q) begin
			pinOe_n[pin_q] = 1'b0;
		end
		addrPinDirection = pin_pulse_timing_pkg::DATA_PIN_DIRECTION_RST;
		done = done_q;
		pready = 1'b1;
		pslverr = psel && penable && !mapped;
		prdata = prdata_q;
	end
endmodule : pin_pulse_timing_unit

// ===== core/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinSync
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gen_sync
			logic stage1_q, stage2_q;
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					stage1_q <= 1'b0;
					stage2_q <= 1'b0;
				end else begin
					stage1_q <= pinIn[i];
					stage2_q <= stage1_q;
				end
			end
			assign pinSync[i] = stage2_q;
		end
	endgenerate
endmodule : pin_sync

// ===== core/tick_divider.sv
`timescale 1ns/1ns
module tick_divider #(
	parameter int DIVIDE = 1000
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic restart,
	output logic tick
);
	logic [15:0] count_q, count_d;

	always_comb begin
		tick = (count_q == 16'(DIVIDE - 1));
		if (restart || tick) begin
			count_d = 16'h0000;
		end else begin
			count_d = count_q + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count_q <= 16'h0000;
		end else begin
			count_q <= count_d;
		end
	end
endmodule : tick_divider

// ===== sim/pin_partner.sv
`timescale 1ns/1ns
module pin_partner (
	input wire logic sys_clk,
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinOe_n,
	output logic [15:0] pinIn
);
	logic [15:0] drvEn = 16'h0000;
	logic [15:0] drvVal = 16'h0000;
	// Device drive first, then ours, else pull-up
	always_comb
		for (int i = 0; i < 16; i++)
			pinIn[i] = !pinOe_n[i] ? pinOut[i] : (drvEn[i] ? drvVal[i] : 1'b1);
	task automatic pulse(input int p, input logic lvl, input int w);
		drvVal[p] <= !lvl;
		drvEn[p] <= 1'b1;
		repeat (300) @(posedge sys_clk);
		drvVal[p] <= lvl;
		repeat (w) @(posedge sys_clk);
		drvVal[p] <= !lvl;
		repeat (300) @(posedge sys_clk);
		drvEn[p] <= 1'b0;
	endtask : pulse
	// RC network: stays high after release, then discharges
	task automatic rc(input int p, input int t);
		@(posedge sys_clk iff pinOe_n[p]);
		drvVal[p] <= 1'b1;
		drvEn[p] <= 1'b1;
		repeat (t) @(posedge sys_clk);
		drvVal[p] <= 1'b0;
		repeat (300) @(posedge sys_clk);
		drvEn[p] <= 1'b0;
	endtask : rc
endmodule : pin_partner

// ===== sim/pin_pulse_timing_sva.sv
`timescale 1ns/1ns
module pin_pulse_timing_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinOe_n,
	input wire logic [7:0] addrPinDirection,
	input wire logic done
);
	// ----------------------------------------
	// Shadow of the command engine
	// ----------------------------------------
	logic wr;
	logic acc;
	logic busy_q, busy_d;
	logic zeroBurst;
	logic [15:0] cyc_q;
	logic [3:0] pin_q;
	logic [2:0] op_q;
	logic [15:0] dur_q;
	int cnt_q, cnt_d;
	assign wr = psel && penable && pwrite;
	assign acc = wr && paddr == pin_pulse_timing_pkg::CMD_OFS && !busy_q && pwdata[7:4] == 4'h0
		&& pwdata[10:8] != 3'h0 && pwdata[10:8] != 3'h7;
	// Burst of zero periods completes in its accept cycle
	assign zeroBurst = pwdata[10:8] == 3'h5 && cyc_q == 16'h0000;
	always_comb begin
		busy_d = acc || (busy_q && !done);
		cnt_d = acc ? 0 : cnt_q + 1;
	end
	always_ff @(posedge sys_clk) begin
		busy_q <= rst_n && busy_d;
		cnt_q <= cnt_d;
		if (acc) begin
			pin_q <= pwdata[3:0];
			op_q <= pwdata[10:8];
		end
		if (wr && paddr == pin_pulse_timing_pkg::DURATION_OFS)
			dur_q <= pwdata[15:0];
		if (wr && paddr == pin_pulse_timing_pkg::CYCLE_COUNT_OFS)
			cyc_q <= pwdata[15:0];
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_acc(logic [2:0] o);
		acc && pwdata[10:8] == o;
	endsequence
	a_err_unmapped: assert property (psel && penable && paddr > 12'h01C |-> pslverr)
		else $error("unmapped access without error");
	a_dir_write: assert property (wr && paddr == 12'h000 |=>
		pinOe_n[7:0] == $past(pwdata[7:0])) else $error("direction write lost");
	a_addr_input: assert property (addrPinDirection == 8'hFF)
		else $error("address pins not input");
	a_done_clear: assert property (acc && done && !zeroBurst |=> !done)
		else $error("done kept over new command");
	a_zero_burst: assert property (acc && zeroBurst |=> done)
		else $error("empty burst not done at once");
	a_rc_charge: assert property (s_acc(3'h6) |=> !pinOe_n[pin_q] && pinOut[pin_q])
		else $error("rc pin not driven high");
	a_done_hold: assert property (done && !acc |=> done)
		else $error("done dropped without command");
	a_low_start: assert property (s_acc(3'h3) |=> ##[0:3] !pinOut[pin_q])
		else $error("low pulse not started");
	a_high_start: assert property (s_acc(3'h4) |=> ##[0:3] pinOut[pin_q])
		else $error("high pulse not started");
	a_pulse_len: assert property ($rose(done) && (op_q == 3'h3 || op_q == 3'h4) |->
		cnt_q >= dur_q * 1000 && cnt_q <= dur_q * 1000 + 4) else $error("pulse length wrong");
	a_low_end: assert property ($rose(done) && op_q == 3'h3 |-> pinOut[pin_q])
		else $error("pin not high after low pulse");
	a_high_end: assert property ($rose(done) && op_q == 3'h4 |-> !pinOut[pin_q])
		else $error("pin not low after high pulse");
endmodule : pin_pulse_timing_sva

// ===== sim/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, done, err;
	logic [15:0] pinIn, pinOut, pinOe_n;
	logic [7:0] addrPinDirection;
	logic [31:0] seed = 32'h7531;
	int nErrors = 0;
	int checkCount = 0;
	int cycles = 0;
	int monPin = 0;
	int highs = 0;
	int lows = 0;
	int rises = 0;
	int expQ[$];
	logic prevLvl = 1'b0;
	pin_pulse_timing_unit u_pin_pulse_timing_unit (.sys_clk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe_n,
		.addrPinDirection, .done);
	pin_partner u_pin_partner (.sys_clk, .pinOut, .pinOe_n, .pinIn);
	initial forever #5 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Pin monitor and watchdog
	// ----------------------------------------
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (pinIn[monPin] && !prevLvl)
			rises <= rises + 1;
		if (pinIn[monPin])
			highs <= highs + 1;
		else
			lows <= lows + 1;
		prevLvl <= pinIn[monPin];
		if (cycles == 80000) begin
			nErrors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic rng(input logic [31:0] seen, input int lo, input int hi);
		check((seen >= lo && seen <= hi) ? 32'(lo) : seen, 32'(lo));
	endtask : rng
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// APB cycle; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic cmd(input logic [2:0] op, input int p);
		apb(1'b1, pin_pulse_timing_pkg::CMD_OFS, {21'h0, op, 8'(p)});
	endtask : cmd
	task automatic wait_done();
		while (done !== 1'b1)
			@(posedge sys_clk);
	endtask : wait_done
	initial begin
		int p, w, r0, h0;
		logic lvl;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h000000FF);
		apb(1'b1, 12'h000, 32'h000000A5);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h000000A5);
		apb(1'b0, 12'h020, 32'h0);
		check(err, 32'h1);
		apb(1'b1, 12'h000, 32'h000000F0);
		$display("registers done");
		for (int k = 0; k < 2; k++) begin
			lvl = k[0];
			p = 2 + k;
			monPin = p;
			apb(1'b1, pin_pulse_timing_pkg::DURATION_OFS, 32'(2 - k));
			r0 = lvl ? highs : lows;
			cmd(lvl ? 3'h4 : 3'h3, p);
			cmd(3'h4, 1);
			wait_done();
			rng((lvl ? highs : lows) - r0, (2 - k) * 1000, (2 - k) * 1000 + 12);
			check(pinIn[p], !lvl);
			check(pinIn[1], 32'h0);
		end
		$display("pulse out done");
		monPin = 0;
		apb(1'b1, pin_pulse_timing_pkg::HIGH_TIME_OFS, 32'h2);
		apb(1'b1, pin_pulse_timing_pkg::CYCLE_TIME_OFS, 32'h5);
		for (int n = 3; n >= 0; n -= 3) begin
			apb(1'b1, pin_pulse_timing_pkg::CYCLE_COUNT_OFS, 32'(n));
			apb(1'b0, pin_pulse_timing_pkg::CYCLE_COUNT_OFS, 32'h0);
			check(rd, 32'(n));
			r0 = rises;
			h0 = highs;
			cmd(3'h5, 0);
			wait_done();
			check(rises - r0, 32'(n));
			rng(highs - h0, n * 600, n * 600 + 6);
			check(pinIn[0], 32'h0);
		end
		$display("cycles done");
		for (int k = 0; k < 4; k++) begin
			lvl = k[0];
			p = 8 + int'(rnd() % 8);
			w = 2000 + int'(rnd() % 3000);
			cmd(lvl ? 3'h2 : 3'h1, p);
			u_pin_partner.pulse(p, lvl, w);
			wait_done();
			apb(1'b0, pin_pulse_timing_pkg::RESULT_OFS, 32'h0);
			rng(rd, w / 1000 - 1, w / 1000 + 1);
			apb(1'b0, pin_pulse_timing_pkg::STATUS_OFS, 32'h0);
			check(rd, 32'h2);
		end
		$display("pulse in done");
		for (int k = 0; k < 2; k++) begin
			p = 8 + int'(rnd() % 8);
			w = k ? 2000 + int'(rnd() % 1000) : 500;
			expQ.push_back((w / 1000 < pin_pulse_timing_pkg::RC_MIN_COUNT) ? 0 : w / 1000);
			cmd(3'h6, p);
			u_pin_partner.rc(p, w);
			wait_done();
			apb(1'b0, pin_pulse_timing_pkg::RESULT_OFS, 32'h0);
			r0 = expQ.pop_front();
			rng(rd, r0 - k, r0 + k);
		end
		$display("rc discharge done");
		cmd(3'h4, 16);
		apb(1'b0, pin_pulse_timing_pkg::STATUS_OFS, 32'h0);
		check(rd, 32'h2);
		$display("pin range done");
		finish_test();
	end
endmodule : testbench
bind pin_pulse_timing_unit pin_pulse_timing_sva u_pin_pulse_timing_sva (.sys_clk, .rst_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pslverr, .pinOut, .pinOe_n, .addrPinDirection, .done);
